// [hw/desc_pkg.sv]
package desc_pkg;
    localparam int          HDR_BYTES      = 8;
    localparam int          DW_BYTES       = 4;
    localparam int          ADDR_W         = 12;
    localparam int          LIST_SLOTS     = 16;
    localparam int          CNT_W          = 10;
    localparam int          CC_LSB         = 4;
    localparam int          CC_W           = 4;
    localparam int          ACT_BIT        = 3;
    localparam int          TOG_BIT        = 2;
    localparam int          CNT_HI_W       = 2;
    localparam int          BYTE_COUNT_LO  = 0;
    localparam int          BYTE_STATUS    = 1;
    localparam int          BYTE_MPS_LO    = 2;
    localparam int          BYTE_MPS_HI    = 3;
    localparam int          BYTE_TOT_LO    = 4;
    localparam int          BYTE_TOT_HI    = 5;
    localparam logic [1:0]  LIST_APER      = 2'h0;
    localparam logic [1:0]  LIST_INTR      = 2'h1;
    localparam logic [1:0]  LIST_ISO0      = 2'h2;
    localparam logic [1:0]  LIST_ISO1      = 2'h3;
    localparam logic [1:0]  FS_OPERATIONAL = 2'h2;
    localparam logic [3:0]  CC_NO_ERROR    = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_PICK   = 4'h1,
        ST_RD0    = 4'h2,
        ST_RD1    = 4'h3,
        ST_RD2    = 4'h4,
        ST_RD3    = 4'h5,
        ST_RD4    = 4'h6,
        ST_RD5    = 4'h7,
        ST_XFER   = 4'h8,
        ST_WAIT   = 4'h9,
        ST_WB0    = 4'ha,
        ST_WB1    = 4'hb,
        ST_NEXT   = 4'hc
    } walk_state_e;
endpackage

// [hw/stream_if.sv]
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// [hw/desc_fifo.sv]
`timescale 1ns/1ps
module desc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_ce,
    stream_if.sink     in_s,
    stream_if.src      out_s
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        for (int k = 0; k < DEPTH; k++) begin
            mem_d[k] = mem_q[k];
        end
        if (push) begin
            mem_d[wr_q] = in_s.data;
            wr_d        = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                mem_q[k] <= '0;
            end
        end else if (i_ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule // desc_fifo

// [hw/desc_walker.sv]
`timescale 1ns/1ps
module desc_walker
    import desc_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int SLOTS      = LIST_SLOTS,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                  I_MCLK,
    input  wire logic                  I_ARST_N,
    input  wire logic                  I_CE,
    input  wire logic [1:0]            I_FUNCTIONAL_STATE_FIELD,
    input  wire logic                  I_APERIODIC_LIST_GO,
    input  wire logic                  I_INTERRUPT_LIST_GO,
    input  wire logic                  I_ISO_LIST0_FULL,
    input  wire logic                  I_ISO_LIST1_FULL,
    input  wire logic [SLOTS-1:0]      I_APERIODIC_SKIP_MAP,
    input  wire logic [SLOTS-1:0]      I_INTERRUPT_SKIP_MAP,
    input  wire logic [ADDR_WIDTH-1:0] I_APERIODIC_BLOCK_SIZE,
    input  wire logic [ADDR_WIDTH-1:0] I_INTERRUPT_BLOCK_SIZE,
    input  wire logic [ADDR_WIDTH-1:0] I_APERIODIC_BASE,
    input  wire logic [ADDR_WIDTH-1:0] I_INTERRUPT_BASE,
    input  wire logic [ADDR_WIDTH-1:0] I_ISO0_BASE,
    input  wire logic [ADDR_WIDTH-1:0] I_ISO1_BASE,
    input  wire logic [ADDR_WIDTH-1:0] I_ISO_LIST_LEN,
    input  wire logic [7:0]            I_MEM_RDATA,
    output logic                       O_MEM_RD,
    output logic                       O_MEM_WR,
    output logic [ADDR_WIDTH-1:0]      O_MEM_ADDR,
    output logic [7:0]                 O_MEM_WDATA,
    output logic                       O_TXN_VALID,
    input  wire logic                  I_TXN_READY,
    output logic [1:0]                 O_TXN_LIST,
    output logic [ADDR_WIDTH-1:0]      O_TXN_ADDR,
    output logic [CNT_W-1:0]           O_TXN_LEN,
    input  wire logic                  I_RES_VALID,
    input  wire logic [CNT_W-1:0]      I_RES_COUNT,
    input  wire logic [CC_W-1:0]       I_RES_CODE,
    input  wire logic                  I_RES_TOGGLE,
    input  wire logic                  I_RES_DONE,
    output logic                       O_BUSY,
    output logic [1:0]                 O_CUR_LIST
);
    localparam int TW = 2 + ADDR_WIDTH + CNT_W;

    logic                  rst_s1_q, rst_n;
    walk_state_e           st_q, st_d;
    logic [1:0]            list_q, list_d;
    logic [ADDR_WIDTH-1:0] ofs_q, ofs_d, hdr_q, hdr_d;
    logic [7:0]            idx_q, idx_d;
    logic [7:0]            b0_q, b0_d, b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
    logic [7:0]            b4_q, b4_d, b5_q, b5_d;
    logic [CNT_W-1:0]      cnt_q, cnt_d;
    logic [CC_W-1:0]       cc_q, cc_d;
    logic                  tog_q, tog_d, act_q, act_d;
    logic [3:0]            pend_q, pend_d;
    logic [ADDR_WIDTH-1:0] base, blk, iso_sp;
    logic [CNT_W-1:0]      tot_len;
    logic                  skip, last;
    logic                  oper;

    stream_if #(.W(TW)) in_s ();
    stream_if #(.W(TW)) out_s ();

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    desc_fifo #(.WIDTH(TW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_ce    (I_CE),
        .in_s    (in_s),
        .out_s   (out_s)
    );

    assign O_TXN_VALID  = out_s.valid;
    assign out_s.ready  = I_TXN_READY;
    assign O_TXN_LIST   = out_s.data[TW-1 -: 2];
    assign O_TXN_ADDR   = out_s.data[CNT_W +: ADDR_WIDTH];
    assign O_TXN_LEN    = out_s.data[CNT_W-1:0];
    assign in_s.data    = {list_q, hdr_q + ADDR_WIDTH'(HDR_BYTES), tot_len};
    assign in_s.valid   = (st_q == ST_XFER);

    assign oper    = (I_FUNCTIONAL_STATE_FIELD == FS_OPERATIONAL);
    assign tot_len = {b5_q[CNT_HI_W-1:0], b4_q};
    // Widen before rounding so a 1023-byte payload does not wrap
    assign iso_sp  = (ADDR_WIDTH'(tot_len) + ADDR_WIDTH'(DW_BYTES - 1))
                     & ~ADDR_WIDTH'(DW_BYTES - 1);

    always_comb begin
        case (list_q)
            LIST_APER: begin
                base = I_APERIODIC_BASE;
                blk  = I_APERIODIC_BLOCK_SIZE;
                skip = I_APERIODIC_SKIP_MAP[idx_q[$clog2(SLOTS)-1:0]];
            end
            LIST_INTR: begin
                base = I_INTERRUPT_BASE;
                blk  = I_INTERRUPT_BLOCK_SIZE;
                skip = I_INTERRUPT_SKIP_MAP[idx_q[$clog2(SLOTS)-1:0]];
            end
            LIST_ISO0: begin
                base = I_ISO0_BASE;
                blk  = '0;
                skip = 1'b0;
            end
            default: begin
                base = I_ISO1_BASE;
                blk  = '0;
                skip = 1'b0;
            end
        endcase
        last = list_q[1] ? (ofs_q >= I_ISO_LIST_LEN)
                         : (idx_q == 8'(SLOTS));
    end

    always_comb begin
        st_d   = st_q;
        list_d = list_q;
        ofs_d  = ofs_q;
        hdr_d  = hdr_q;
        idx_d  = idx_q;
        b0_d   = b0_q;
        b1_d   = b1_q;
        b2_d   = b2_q;
        b3_d   = b3_q;
        b4_d   = b4_q;
        b5_d   = b5_q;
        cnt_d  = cnt_q;
        cc_d   = cc_q;
        tog_d  = tog_q;
        act_d  = act_q;
        pend_d = pend_q | {I_ISO_LIST1_FULL, I_ISO_LIST0_FULL,
                           I_INTERRUPT_LIST_GO, I_APERIODIC_LIST_GO};
        pend_d = pend_d & {I_ISO_LIST1_FULL, I_ISO_LIST0_FULL,
                           I_INTERRUPT_LIST_GO, I_APERIODIC_LIST_GO};
        O_MEM_RD    = 1'b0;
        O_MEM_WR    = 1'b0;
        O_MEM_ADDR  = hdr_q;
        O_MEM_WDATA = 8'h00;
        case (st_q)
            ST_IDLE: begin
                if (oper && pend_q != 4'h0) begin
                    st_d = ST_PICK;
                end
            end
            ST_PICK: begin
                st_d  = ST_IDLE;
                idx_d = '0;
                ofs_d = '0;
                for (int k = 3; k >= 0; k--) begin
                    if (pend_q[k]) begin
                        list_d = 2'(k);
                        st_d   = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                hdr_d = base + ofs_q;
                if (!oper || last) begin
                    pend_d[list_q] = 1'b0;
                    st_d           = ST_IDLE;
                end else if (skip) begin
                    idx_d = idx_q + 8'h01;
                    ofs_d = ofs_q + blk + ADDR_WIDTH'(HDR_BYTES);
                end else begin
                    st_d = ST_RD0;
                end
            end
            ST_RD0: begin
                O_MEM_RD   = 1'b1;
                O_MEM_ADDR = hdr_q + ADDR_WIDTH'(BYTE_COUNT_LO);
                st_d       = ST_RD1;
            end
            ST_RD1: begin
                O_MEM_RD   = 1'b1;
                O_MEM_ADDR = hdr_q + ADDR_WIDTH'(BYTE_STATUS);
                b0_d       = I_MEM_RDATA;
                st_d       = ST_RD2;
            end
            ST_RD2: begin
                O_MEM_RD   = 1'b1;
                O_MEM_ADDR = hdr_q + ADDR_WIDTH'(BYTE_MPS_LO);
                b1_d       = I_MEM_RDATA;
                st_d       = ST_RD3;
            end
            ST_RD3: begin
                O_MEM_RD   = 1'b1;
                O_MEM_ADDR = hdr_q + ADDR_WIDTH'(BYTE_TOT_LO);
                b2_d       = I_MEM_RDATA;
                st_d       = ST_RD4;
            end
            ST_RD4: begin
                O_MEM_RD   = 1'b1;
                O_MEM_ADDR = hdr_q + ADDR_WIDTH'(BYTE_TOT_HI);
                b4_d       = I_MEM_RDATA;
                st_d       = ST_RD5;
            end
            ST_RD5: begin
                b5_d  = I_MEM_RDATA;
                act_d = b1_q[ACT_BIT];
                tog_d = b1_q[TOG_BIT];
                cnt_d = {b1_q[CNT_HI_W-1:0], b0_q};
                cc_d  = b1_q[CC_LSB +: CC_W];
                st_d  = b1_q[ACT_BIT] ? ST_XFER : ST_WB0;
                if (!b1_q[ACT_BIT]) begin
                    st_d = ST_WB0;
                end
            end
            ST_XFER: begin
                if (in_s.ready) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (I_RES_VALID) begin
                    cnt_d = I_RES_COUNT;
                    cc_d  = I_RES_CODE;
                    tog_d = I_RES_TOGGLE;
                    act_d = ~I_RES_DONE & (I_RES_CODE == CC_NO_ERROR);
                    st_d  = ST_WB0;
                end
            end
            ST_WB0: begin
                O_MEM_WR    = 1'b1;
                O_MEM_ADDR  = hdr_q + ADDR_WIDTH'(BYTE_COUNT_LO);
                O_MEM_WDATA = cnt_q[7:0];
                st_d        = ST_WB1;
            end
            ST_WB1: begin
                O_MEM_WR    = 1'b1;
                O_MEM_ADDR  = hdr_q + ADDR_WIDTH'(BYTE_STATUS);
                O_MEM_WDATA = {cc_q, act_q, tog_q, cnt_q[CNT_W-1 -: CNT_HI_W]};
                idx_d       = idx_q + 8'h01;
                if (list_q[1]) begin
                    ofs_d = ofs_q + iso_sp + ADDR_WIDTH'(HDR_BYTES);
                end else begin
                    ofs_d = ofs_q + blk + ADDR_WIDTH'(HDR_BYTES);
                end
                st_d = ST_NEXT;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_IDLE;
            list_q <= LIST_APER;
            ofs_q  <= '0;
            hdr_q  <= '0;
            idx_q  <= '0;
            b0_q   <= '0;
            b1_q   <= '0;
            b2_q   <= '0;
            b3_q   <= '0;
            b4_q   <= '0;
            b5_q   <= '0;
            cnt_q  <= '0;
            cc_q   <= '0;
            tog_q  <= 1'b0;
            act_q  <= 1'b0;
            pend_q <= '0;
        end else if (I_CE) begin
            st_q   <= st_d;
            list_q <= list_d;
            ofs_q  <= ofs_d;
            hdr_q  <= hdr_d;
            idx_q  <= idx_d;
            b0_q   <= b0_d;
            b1_q   <= b1_d;
            b2_q   <= b2_d;
            b3_q   <= b3_d;
            b4_q   <= b4_d;
            b5_q   <= b5_d;
            cnt_q  <= cnt_d;
            cc_q   <= cc_d;
            tog_q  <= tog_d;
            act_q  <= act_d;
            pend_q <= pend_d;
        end
    end

    assign O_BUSY     = (st_q != ST_IDLE);
    assign O_CUR_LIST = list_q;
endmodule // desc_walker

// [tb/desc_walker_asserts.sv]
`timescale 1ns/1ps
module desc_walker_asserts
    import desc_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input wire logic                  I_MCLK,
    input wire logic                  I_ARST_N,
    input wire logic [1:0]            I_FUNCTIONAL_STATE_FIELD,
    input wire logic                  I_APERIODIC_LIST_GO,
    input wire logic                  I_INTERRUPT_LIST_GO,
    input wire logic                  I_ISO_LIST0_FULL,
    input wire logic                  I_ISO_LIST1_FULL,
    input wire logic                  O_MEM_RD,
    input wire logic                  O_MEM_WR,
    input wire logic [ADDR_WIDTH-1:0] O_MEM_ADDR,
    input wire logic [7:0]            O_MEM_WDATA,
    input wire logic                  O_TXN_VALID,
    input wire logic                  I_TXN_READY,
    input wire logic [1:0]            O_TXN_LIST,
    input wire logic [ADDR_WIDTH-1:0] O_TXN_ADDR,
    input wire logic [CNT_W-1:0]      O_TXN_LEN,
    input wire logic                  I_RES_VALID,
    input wire logic [CNT_W-1:0]      I_RES_COUNT,
    input wire logic [CC_W-1:0]       I_RES_CODE,
    input wire logic                  I_RES_TOGGLE,
    input wire logic                  I_RES_DONE,
    input wire logic                  O_BUSY
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);

    // Header bytes owed after the latest transaction result
    logic [7:0] exp_lo_q;
    logic [7:0] exp_st_q;
    logic       res_pend_q;
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            res_pend_q <= 1'b0;
            exp_lo_q   <= 8'h00;
            exp_st_q   <= 8'h00;
        end else if (I_RES_VALID) begin
            res_pend_q <= 1'b1;
            exp_lo_q   <= I_RES_COUNT[7:0];
            exp_st_q   <= {I_RES_CODE, !I_RES_DONE && (I_RES_CODE == CC_NO_ERROR),
                           I_RES_TOGGLE, I_RES_COUNT[9:8]};
        end else if ($fell(O_MEM_WR)) begin
            res_pend_q <= 1'b0;
        end
    end

    sequence s_hdr_steps;
        ##1 O_MEM_ADDR == $past(O_MEM_ADDR) + 12'h1 ##1 O_MEM_ADDR == $past(O_MEM_ADDR) + 12'h1
        ##1 O_MEM_ADDR == $past(O_MEM_ADDR) + 12'h2 ##1 O_MEM_ADDR == $past(O_MEM_ADDR) + 12'h1;
    endsequence
    sequence s_wb_pair;
        O_MEM_WR ##1 O_MEM_WR && O_MEM_ADDR == $past(O_MEM_ADDR) + 12'h1 ##1 !O_MEM_WR;
    endsequence
    property p_hdr_len;
        $rose(O_MEM_RD) |-> O_MEM_RD[*5] ##1 !O_MEM_RD;
    endproperty
    property p_hdr_addr;
        $rose(O_MEM_RD) |-> s_hdr_steps;
    endproperty
    property p_wb_pair;
        $rose(O_MEM_WR) |-> s_wb_pair;
    endproperty
    property p_wb_data;
        $rose(O_MEM_WR) && res_pend_q |-> O_MEM_WDATA == exp_lo_q ##1 O_MEM_WDATA == exp_st_q;
    endproperty
    property p_wb_soon;
        I_RES_VALID |-> ##[1:4] $rose(O_MEM_WR);
    endproperty
    property p_oper_gate;
        !O_BUSY && I_FUNCTIONAL_STATE_FIELD != FS_OPERATIONAL |=> !O_BUSY;
    endproperty
    property p_go_gate;
        !O_BUSY && !(I_APERIODIC_LIST_GO || I_INTERRUPT_LIST_GO || I_ISO_LIST0_FULL
                     || I_ISO_LIST1_FULL) |=> !O_BUSY;
    endproperty
    property p_txn_hold;
        O_TXN_VALID && !I_TXN_READY |=> O_TXN_VALID && $stable(O_TXN_ADDR)
            && $stable(O_TXN_LEN) && $stable(O_TXN_LIST);
    endproperty

    a_hdr_len: assert property (p_hdr_len) else $error("header read burst length");
    a_hdr_addr: assert property (p_hdr_addr) else $error("header read addresses");
    a_wb_pair: assert property (p_wb_pair) else $error("status write pair");
    a_wb_data: assert property (p_wb_data) else $error("status write data");
    a_wb_soon: assert property (p_wb_soon) else $error("status write late");
    a_oper_gate: assert property (p_oper_gate) else $error("walk while not operational");
    a_go_gate: assert property (p_go_gate) else $error("walk without enabled list");
    a_txn_hold: assert property (p_txn_hold) else $error("transaction changed while held");
endmodule // desc_walker_asserts

// [tb/desc_far_model.sv]
`timescale 1ns/1ps
module desc_far_model
    import desc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_slow,
    input  wire logic              i_rd,
    input  wire logic              i_wr,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    output logic [7:0]             o_rdata = 8'h00,
    input  wire logic              i_txn_valid,
    output logic                   o_txn_ready = 1'b0,
    input  wire logic [1:0]        i_txn_list,
    input  wire logic [ADDR_W-1:0] i_txn_addr,
    input  wire logic [CNT_W-1:0]  i_txn_len,
    output logic                   o_res_valid = 1'b0,
    output logic [CNT_W-1:0]       o_res_count = '0,
    output logic [CC_W-1:0]        o_res_code,
    output logic                   o_res_toggle = 1'b0,
    output logic                   o_res_done
);
    logic [7:0]        mem [2**ADDR_W];
    logic [1:0]        lq [$];
    logic [ADDR_W-1:0] aq [$];
    logic [CNT_W-1:0]  nq [$];
    logic [2:0]        wait_q = 3'h0;
    logic              owe_q  = 1'b0;
    initial begin
        foreach (mem[a]) mem[a] = 8'h00;
    end
    assign o_res_code = CC_NO_ERROR;
    // Slow partner leaves descriptors unfinished, so active stays set
    assign o_res_done = ~i_slow;
    always @(posedge i_clk) begin
        o_res_valid <= 1'b0;
        // Read data lasts one cycle, then turns to garbage
        o_rdata     <= i_rd ? mem[i_addr] : ~o_rdata;
        if (i_wr) mem[i_addr] <= i_wdata;
        if (o_txn_ready && i_txn_valid) begin
            o_res_toggle <= 1'(nq.size());
            o_res_count  <= i_txn_len;
            lq.push_back(i_txn_list);
            aq.push_back(i_txn_addr);
            nq.push_back(i_txn_len);
            o_txn_ready  <= 1'b0;
            owe_q        <= 1'b1;
            wait_q       <= i_slow ? 3'h5 : 3'h0;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (owe_q) begin
            o_res_valid <= 1'b1;
            owe_q       <= 1'b0;
            wait_q      <= i_slow ? 3'h4 : 3'h0;
        end else begin
            o_txn_ready <= i_txn_valid;
        end
    end
endmodule // desc_far_model

// [tb/usb_host_descriptor_buffer_tb_top.sv]
`timescale 1ns/1ps
bind desc_walker desc_walker_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_FUNCTIONAL_STATE_FIELD(I_FUNCTIONAL_STATE_FIELD),
    .I_APERIODIC_LIST_GO(I_APERIODIC_LIST_GO), .I_INTERRUPT_LIST_GO(I_INTERRUPT_LIST_GO),
    .I_ISO_LIST0_FULL(I_ISO_LIST0_FULL), .I_ISO_LIST1_FULL(I_ISO_LIST1_FULL),
    .O_MEM_RD(O_MEM_RD), .O_MEM_WR(O_MEM_WR), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
    .O_TXN_VALID(O_TXN_VALID), .I_TXN_READY(I_TXN_READY), .O_TXN_LIST(O_TXN_LIST),
    .O_TXN_ADDR(O_TXN_ADDR), .O_TXN_LEN(O_TXN_LEN), .I_RES_VALID(I_RES_VALID),
    .I_RES_COUNT(I_RES_COUNT), .I_RES_CODE(I_RES_CODE), .I_RES_TOGGLE(I_RES_TOGGLE),
    .I_RES_DONE(I_RES_DONE), .O_BUSY(O_BUSY));
module usb_host_descriptor_buffer_tb_top;
    import desc_pkg::*;
    logic              mclk = 1'b0;
    logic              arst_n, ce, slow, aper_go, intr_go, iso0_go, iso1_go;
    logic [1:0]        fs, txn_list, cur_list;
    logic [15:0]       aper_skip, intr_skip;
    logic [ADDR_W-1:0] aper_size, intr_size, iso_len, mem_addr, txn_addr;
    logic              mem_rd, mem_wr, txn_valid, txn_ready, res_valid, res_toggle, res_done, busy;
    logic [7:0]        mem_wdata, mem_rdata;
    logic [CNT_W-1:0]  txn_len, res_count;
    logic [CC_W-1:0]   res_code;
    int                error_cnt = 0;
    int                num_checks = 0;
    int                cycles = 0;

    desc_walker #(.ADDR_WIDTH(ADDR_W), .SLOTS(LIST_SLOTS), .FIFO_DEPTH(8)) DUT (
        .I_MCLK(mclk), .I_ARST_N(arst_n), .I_CE(ce), .I_FUNCTIONAL_STATE_FIELD(fs),
        .I_APERIODIC_LIST_GO(aper_go), .I_INTERRUPT_LIST_GO(intr_go),
        .I_ISO_LIST0_FULL(iso0_go), .I_ISO_LIST1_FULL(iso1_go),
        .I_APERIODIC_SKIP_MAP(aper_skip), .I_INTERRUPT_SKIP_MAP(intr_skip),
        .I_APERIODIC_BLOCK_SIZE(aper_size), .I_INTERRUPT_BLOCK_SIZE(intr_size),
        .I_APERIODIC_BASE(12'h000), .I_INTERRUPT_BASE(12'h280), .I_ISO0_BASE(12'h380),
        .I_ISO1_BASE(12'h8a0), .I_ISO_LIST_LEN(iso_len), .I_MEM_RDATA(mem_rdata),
        .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
        .O_TXN_VALID(txn_valid), .I_TXN_READY(txn_ready), .O_TXN_LIST(txn_list),
        .O_TXN_ADDR(txn_addr), .O_TXN_LEN(txn_len), .I_RES_VALID(res_valid),
        .I_RES_COUNT(res_count), .I_RES_CODE(res_code), .I_RES_TOGGLE(res_toggle),
        .I_RES_DONE(res_done), .O_BUSY(busy), .O_CUR_LIST(cur_list));
    desc_far_model mdl (
        .i_clk(mclk), .i_slow(slow), .i_rd(mem_rd), .i_wr(mem_wr), .i_addr(mem_addr),
        .i_wdata(mem_wdata), .o_rdata(mem_rdata), .i_txn_valid(txn_valid),
        .o_txn_ready(txn_ready), .i_txn_list(txn_list), .i_txn_addr(txn_addr),
        .i_txn_len(txn_len), .o_res_valid(res_valid), .o_res_count(res_count),
        .o_res_code(res_code), .o_res_toggle(res_toggle), .o_res_done(res_done));

    always #5 mclk = ~mclk;

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reserved bits stay zero, header sits right before its payload
    task automatic put_hdr(input logic [11:0] a, input logic act, input logic [9:0] tot);
        mdl.mem[a + 12'h1] = {4'h0, act, 3'h0};
        mdl.mem[a + 12'h4] = tot[7:0];
        mdl.mem[a + 12'h5] = {6'h00, tot[9:8]};
    endtask

    task automatic chk_txn(input int i, input logic [1:0] l, input logic [11:0] a,
                           input logic [9:0] n);
        chk(16'(mdl.lq[i]), 16'(l));
        chk(16'(mdl.aq[i]), 16'(a));
        chk(16'(mdl.nq[i]), 16'(n));
        chk(16'(mdl.mem[a - 12'h8]), 16'(n[7:0]));
        chk(16'(mdl.mem[a - 12'h7]), {12'h000, slow, 1'(i), n[9:8]});
    endtask

    task automatic wait_txns(input int n);
        for (int k = 0; k < 4000 && mdl.nq.size() < n; k++) @(posedge mclk);
        chk(16'(mdl.nq.size()), 16'(n));
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 2500 && busy !== 1'b0; k++) @(posedge mclk);
        chk(16'(busy), 16'h0);
    endtask

    task automatic t_fixed_lists;
        int i;
        for (int n = 0; n < 16; n++) put_hdr(12'(n * 40), 1'b1, 10'd4);
        put_hdr(12'h280, 1'b1, 10'd6);
        fs <= FS_OPERATIONAL;
        repeat (10) @(posedge mclk);
        chk(16'(busy), 16'h0);
        fs <= 2'h0;
        aper_go <= 1'b1;
        intr_go <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(16'(busy), 16'h0);
        fs <= FS_OPERATIONAL;
        wait_txns(14);
        chk(16'(cur_list), 16'(LIST_APER));
        aper_go <= 1'b0;
        wait_txns(15);
        intr_go <= 1'b0;
        wait_idle();
        chk(16'(mdl.nq.size()), 16'd15);
        i = 0;
        for (int n = 0; n < 16; n++) begin
            if (n == 0 || n == 4) begin
                chk(16'(mdl.mem[12'(n * 40 + 1)]), 16'h0008);
            end else begin
                chk_txn(i, LIST_APER, 12'(n * 40 + 8), 10'd4);
                i++;
            end
        end
        chk_txn(14, LIST_INTR, 12'h288, 10'd6);
    endtask

    task automatic t_iso_lists;
        int off [4] = '{0, 208, 228, 1260};
        int len [4] = '{200, 10, 1023, 30};
        for (int k = 0; k < 4; k++) put_hdr(12'h380 + 12'(off[k]), 1'b1, 10'(len[k]));
        put_hdr(12'h8a0, 1'b1, 10'd16);
        slow <= 1'b1;
        iso0_go <= 1'b1;
        iso1_go <= 1'b1;
        wait_txns(19);
        iso0_go <= 1'b0;
        wait_txns(20);
        chk(16'(cur_list), 16'(LIST_ISO1));
        iso1_go <= 1'b0;
        wait_idle();
        for (int k = 0; k < 4; k++) begin
            chk_txn(15 + k, LIST_ISO0, 12'h388 + 12'(off[k]), 10'(len[k]));
        end
        chk_txn(19, LIST_ISO1, 12'h8a8, 10'd16);
    endtask

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        slow = 1'b0;
        fs = 2'h0;
        {aper_go, intr_go, iso0_go, iso1_go} = 4'h0;
        aper_skip = 16'h0011;
        intr_skip = 16'hfffe;
        aper_size = 12'd32;
        intr_size = 12'd8;
        iso_len = 12'd1300;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_fixed_lists();
        t_iso_lists();
        wrap_up();
    end
endmodule // usb_host_descriptor_buffer_tb_top
